// ---- sim/dac_trim_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module dac_trim_checker
  import dac_trim_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sif_sel_n,
  input wire logic sif_clk,
  input wire logic sif_dout_oe,
  input wire logic sync_in,
  input wire logic iotest_ena,
  input wire logic [SAMPLE_BITS-1:0] corrected_a,
  input wire logic trim_sync,
  input wire logic [READ_START_BITS-1:0] fifo_read_ptr,
  input wire logic [GAIN_BITS-1:0] coarse_gain,
  input wire logic [GAIN_BITS:0] gain_steps,
  input wire logic sleep_a,
  input wire logic pattern_error
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_sync_after_write:
    assert property (trim_sync |-> $past(sif_clk, 2) && !$past(sif_sel_n, 2))
    else $error("offset sync pulse without a finished frame");
  a_sync_one_cycle:
    assert property (trim_sync |=> !trim_sync)
    else $error("offset sync pulse longer than one cycle");
  a_gain_plus_one:
    assert property ($stable(coarse_gain) |-> gain_steps == coarse_gain + 5'h01)
    else $error("gain steps not code plus one");
  a_ptr_free_run:
    assert property (!$rose(sync_in) |=> fifo_read_ptr == $past(fifo_read_ptr) + 3'h1)
    else $error("read pointer did not advance");
  a_oe_release:
    assert property (sif_sel_n |=> !sif_dout_oe)
    else $error("serial output still driven after deselect");
  a_sleep_a_zero:
    assert property (sleep_a [*2] |-> corrected_a == '0)
    else $error("sleeping channel a not zero");
  a_error_sticky:
    assert property (pattern_error && !$rose(sync_in) |=> pattern_error)
    else $error("pattern error cleared without a new start");
  a_error_idle:
    assert property (!iotest_ena && !pattern_error |=> !pattern_error)
    else $error("pattern error raised while checking is off");
endmodule // dac_trim_checker
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb
  import dac_trim_pkg::*;
;
  logic clock = 0, arst_n = 0, sif_sel_n = 1, sif_clk = 0, sif_din = 0;
  logic sync_in = 0, iotest_ena = 0, sif_dout, sif_dout_oe, trim_sync;
  logic [13:0] data_in = 0, sample_a = 0, sample_b = 0, check_word5, check_word6, check_word7;
  logic [13:0] corrected_a, corrected_b, w [8];
  logic [2:0] fifo_read_ptr;
  logic [3:0] coarse_gain;
  logic [4:0] gain_steps;
  logic fuse_sleep, tsense_sleep, clk_receiver_ena, sleep_a, sleep_b, pattern_error, pattern_busy;
  logic [15:0] exp_q [$], seen_q [$], q, v, rsv;
  logic [31:0] seed = 29;
  int n_errors = 0, comparisons = 0, cycles = 0;
  int n_syncs = 0;
  event got;
  wire [15:0] pwr = {coarse_gain, fuse_sleep, 2'h0, tsense_sleep, clk_receiver_ena,
    sleep_a, sleep_b, 5'h00};

  dac_trim_regs dut (.clock, .arst_n, .sif_sel_n, .sif_clk, .sif_din, .sif_dout, .sif_dout_oe,
    .sync_in, .iotest_ena, .data_in, .check_word5, .check_word6, .check_word7, .sample_a,
    .sample_b, .corrected_a, .corrected_b, .trim_sync, .fifo_read_ptr, .coarse_gain,
    .gain_steps, .fuse_sleep, .tsense_sleep, .clk_receiver_ena, .sleep_a, .sleep_b,
    .pattern_error, .pattern_busy);

  always #4 clock = ~clock;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // seen values queue too, so two notes in one time step are never lost
  task automatic observe(input logic [15:0] s, input logic [15:0] e);
    exp_q.push_back(e);
    seen_q.push_back(s);
    -> got;
  endtask

  always @(got) begin
    while (seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
  end

  // low and high phases of four clocks keep above the three-clock minimum
  task automatic frame(input logic rw, input logic [6:0] a, input logic [15:0] d);
    logic [23:0] f;
    f = {rw, a, d};
    @(posedge clock);
    sif_sel_n <= 0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clock);
      sif_clk <= 0;
      sif_din <= f[i];
      repeat (3) @(posedge clock);
      @(negedge clock);
      if (i < 16) q[i] = sif_dout;
      @(posedge clock);
      sif_clk <= 1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock);
    sif_clk <= 0;
    repeat (3) @(posedge clock);
    sif_sel_n <= 1;
    repeat (3) @(posedge clock);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    frame(1, a, 16'h0000);
    observe(q, e);
  endtask

  task automatic results();
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 12000) begin
      n_errors++;
      results();
    end
  end

  // each offset sync pulse lasts one cycle, so it is counted once
  always @(posedge clock) begin
    if (trim_sync === 1'b1) n_syncs++;
  end

  initial begin
    w[5] = 14'(xs());
    w[6] = 14'(xs());
    w[7] = 14'(xs());
    for (int i = 0; i < 5; i++) w[i] = REG_RESET[IDX_CHECK0 + i][13:0];
    repeat (20) @(posedge clock);
    check_word5 <= w[5];
    check_word6 <= w[6];
    check_word7 <= w[7];
    arst_n <= 1;
    repeat (2) @(posedge clock);
    for (int i = 0; i < REG_COUNT; i++) begin
      rd(7'(ADDR_TRIM_A + i), REG_RESET[i]);
    end
    observe(pwr, RST_GAIN_POWER & 16'hf9e0);
    observe(16'(gain_steps), 16'h0010);
    // last pass hits the unmapped word after the check words
    for (int i = 0; i <= REG_COUNT; i++) begin
      v = 16'(xs());
      rsv = (i == 0) ? 16'he000 : (i == 2) ? 16'h061f : (i == 3) ? 16'hffff :
        (i >= IDX_CHECK0 && i < REG_COUNT) ? 16'hc000 : 16'h0000;
      v = (v & ~rsv) | (REG_RESET[i % REG_COUNT] & rsv);
      frame(0, 7'(ADDR_TRIM_A + i), v);
      if (i >= IDX_CHECK0 && i < REG_COUNT) w[i - IDX_CHECK0] = v[13:0];
      rd(7'(ADDR_TRIM_A + i), i < REG_COUNT ? v & REG_MASK[i % REG_COUNT] : 16'h0000);
      if (i == IDX_GAIN_POWER) observe(pwr, v & 16'hf9e0);
      if (i == IDX_GAIN_POWER) observe(16'(gain_steps), 16'(v[15:12]) + 16'h0001);
    end
    frame(0, ADDR_GAIN_POWER, RST_GAIN_POWER);
    frame(0, ADDR_TRIM_A, 16'h4005);
    frame(0, ADDR_TRIM_B, 16'h5ffb);
    observe(16'(n_syncs), 16'h0002);
    // offsets live after the autosync, sums clipped
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      sample_a <= k ? 14'h0064 : 14'h1fff;
      sample_b <= k ? 14'h0064 : 14'h2000;
      repeat (2) @(posedge clock);
      @(negedge clock);
      observe(16'(corrected_a), k ? 16'h0069 : 16'h1fff);
      observe(16'(corrected_b), k ? 16'h005f : 16'h2000);
    end
    // word zero aligned to the sync rise
    for (int r = 0; r < 3; r++) begin
      @(posedge clock);
      sync_in <= 1;
      iotest_ena <= 1;
      data_in <= w[0];
      for (int i = 1; i < 16; i++) begin
        @(posedge clock);
        sync_in <= 0;
        data_in <= w[i % 8] ^ 14'(r == 1 && i == 11);
        if (i == 1) begin
          @(negedge clock);
          observe(16'(fifo_read_ptr), 16'h0002);
          observe(16'(pattern_busy), 16'h0001);
        end
      end
      @(posedge clock);
      iotest_ena <= 0;
      @(posedge clock);
      @(negedge clock);
      observe(16'(pattern_error), 16'(r == 1));
      observe(16'(pattern_busy), 16'h0000);
    end
    frame(0, ADDR_GAIN_POWER, 16'hf0e0);
    @(negedge clock);
    observe({corrected_a, 2'h0}, 16'h0000);
    observe({corrected_b, 2'h0}, 16'h0000);
    // let the compare process drain the last notes before the verdict
    @(posedge clock);
    results();
  end
endmodule // tb

bind dac_trim_regs dac_trim_checker chk (.clock(clock), .arst_n(arst_n),
  .sif_sel_n(sif_sel_n), .sif_clk(sif_clk), .sif_dout_oe(sif_dout_oe), .sync_in(sync_in),
  .iotest_ena(iotest_ena), .corrected_a(corrected_a), .trim_sync(trim_sync),
  .fifo_read_ptr(fifo_read_ptr), .coarse_gain(coarse_gain), .gain_steps(gain_steps),
  .sleep_a(sleep_a), .pattern_error(pattern_error));
`default_nettype wire

// ---- verilog/dac_trim_pkg.sv ----
`default_nettype none
package dac_trim_pkg;

  // serial frame: one read/write flag, seven address bits, sixteen data bits
  localparam int SIF_HEADER_BITS = 8;
  localparam int SIF_FRAME_BITS = 24;
  localparam int WORD_BITS = 16;

  localparam logic [6:0] ADDR_TRIM_A = 7'h08;
  localparam logic [6:0] ADDR_TRIM_B = 7'h09;
  localparam logic [6:0] ADDR_GAIN_POWER = 7'h0a;
  localparam logic [6:0] ADDR_RSVD_B = 7'h0b;
  localparam logic [6:0] ADDR_CHECK0 = 7'h0c;
  localparam logic [6:0] ADDR_CHECK1 = 7'h0d;
  localparam logic [6:0] ADDR_CHECK2 = 7'h0e;
  localparam logic [6:0] ADDR_CHECK3 = 7'h0f;
  localparam logic [6:0] ADDR_CHECK4 = 7'h10;
  localparam int REG_COUNT = 9;

  localparam logic [15:0] RST_TRIM_A = 16'h4000;
  localparam logic [15:0] RST_TRIM_B = 16'h8000;
  localparam logic [15:0] RST_GAIN_POWER = 16'hf080;
  localparam logic [15:0] RST_RSVD_B = 16'h1111;
  localparam logic [15:0] RST_CHECK0 = 16'h3a7a;
  localparam logic [15:0] RST_CHECK1 = 16'h36b6;
  localparam logic [15:0] RST_CHECK2 = 16'h2aea;
  localparam logic [15:0] RST_CHECK3 = 16'h0545;
  localparam logic [15:0] RST_CHECK4 = 16'h1a1a;

  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] MASK_CHECK = 16'h3fff;

  // indexed from ADDR_TRIM_A upward
  localparam logic [15:0] REG_RESET [REG_COUNT] = '{
    RST_TRIM_A, RST_TRIM_B, RST_GAIN_POWER, RST_RSVD_B,
    RST_CHECK0, RST_CHECK1, RST_CHECK2, RST_CHECK3, RST_CHECK4};
  localparam logic [15:0] REG_MASK [REG_COUNT] = '{
    MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
    MASK_CHECK, MASK_CHECK, MASK_CHECK, MASK_CHECK, MASK_CHECK};

  localparam int IDX_TRIM_A = 0;
  localparam int IDX_TRIM_B = 1;
  localparam int IDX_GAIN_POWER = 2;
  localparam int IDX_CHECK0 = 4;

  localparam int TRIM_BITS = 13;
  localparam int READ_START_LSB = 13;
  localparam int READ_START_BITS = 3;
  localparam int GAIN_LSB = 12;
  localparam int GAIN_BITS = 4;
  localparam int FUSE_SLEEP_BIT = 11;
  localparam int TSENSE_SLEEP_BIT = 8;
  localparam int CLKRECV_ENA_BIT = 7;
  localparam int SLEEP_A_BIT = 6;
  localparam int SLEEP_B_BIT = 5;

  localparam int SAMPLE_BITS = 14;
  localparam int CHECK_WORDS = 8;
  localparam int CHECK_REG_WORDS = 5;

  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_RUN = 2'b01
  } chk_state_t;

endpackage
`default_nettype wire

// ---- verilog/dac_trim_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module dac_trim_regs
  import dac_trim_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sif_sel_n,
  input wire logic sif_clk,
  input wire logic sif_din,
  output logic sif_dout,
  output logic sif_dout_oe,
  input wire logic sync_in,
  input wire logic iotest_ena,
  input wire logic [SAMPLE_BITS-1:0] data_in,
  input wire logic [SAMPLE_BITS-1:0] check_word5,
  input wire logic [SAMPLE_BITS-1:0] check_word6,
  input wire logic [SAMPLE_BITS-1:0] check_word7,
  input wire logic [SAMPLE_BITS-1:0] sample_a,
  input wire logic [SAMPLE_BITS-1:0] sample_b,
  output logic [SAMPLE_BITS-1:0] corrected_a,
  output logic [SAMPLE_BITS-1:0] corrected_b,
  output logic trim_sync,
  output logic [READ_START_BITS-1:0] fifo_read_ptr,
  output logic [GAIN_BITS-1:0] coarse_gain,
  output logic [GAIN_BITS:0] gain_steps,
  output logic fuse_sleep,
  output logic tsense_sleep,
  output logic clk_receiver_ena,
  output logic sleep_a,
  output logic sleep_b,
  output logic pattern_error,
  output logic pattern_busy
);

  logic [6:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] rd_data;
  logic [15:0] cfg_q [REG_COUNT];

  sif_serial_port u_port (
    .clock(clock),
    .arst_n(arst_n),
    .sif_sel_n(sif_sel_n),
    .sif_clk(sif_clk),
    .sif_din(sif_din),
    .sif_dout(sif_dout),
    .sif_dout_oe(sif_dout_oe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rd_data(rd_data)
  );

  // read data is an or-chain of the selected entries, so no index leaves the array
  logic [15:0] rd_terms [REG_COUNT + 1];
  assign rd_terms[0] = 16'h0000;

  // register array, one entry per word from the channel A offset upward
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
    wire sel = reg_addr == ADDR_TRIM_A + 7'(i);
    wire hit = wr_stb && sel;
    // unmapped addresses select no entry and read as zero
    assign rd_terms[i + 1] = rd_terms[i] | (sel ? cfg_q[i] : 16'h0000);
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cfg_q[i] <= REG_RESET[i];
      end else if (hit) begin
        cfg_q[i] <= wr_data & REG_MASK[i];
      end
    end
  end

  // reserved words are stored and read back as written, so a write-back of the
  // reset value keeps them at a known value
  // reserved fields read back, except check word bits 15:14, which read as zero
  assign rd_data = rd_terms[REG_COUNT];

  wire [15:0] trim_a_word = cfg_q[IDX_TRIM_A];
  wire [15:0] trim_b_word = cfg_q[IDX_TRIM_B];
  wire [15:0] power_word = cfg_q[IDX_GAIN_POWER];

  // sync input is synchronous to clock, so a one-flop edge detector suffices
  logic sync_last_q;
  wire sync_rise = sync_in & ~sync_last_q;

  wire auto_sync = wr_stb && reg_addr == ADDR_TRIM_B;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_last_q <= 1'b0;
      trim_sync <= 1'b0;
    end else begin
      sync_last_q <= sync_in;
      trim_sync <= auto_sync;
    end
  end

  // both channels take the new offsets on the same edge
  wire [TRIM_BITS-1:0] trim_a = trim_a_word[TRIM_BITS-1:0];
  wire [TRIM_BITS-1:0] trim_b = trim_b_word[TRIM_BITS-1:0];

  dc_trim_channel #(
    .SAMPLE_W(SAMPLE_BITS),
    .TRIM_W(TRIM_BITS)
  ) u_trim_a (
    .clock(clock),
    .arst_n(arst_n),
    .sample_in(sample_a),
    .trim_value(trim_a),
    .sync_pulse(trim_sync),
    .sleep(sleep_a),
    .sample_out(corrected_a)
  );

  dc_trim_channel #(
    .SAMPLE_W(SAMPLE_BITS),
    .TRIM_W(TRIM_BITS)
  ) u_trim_b (
    .clock(clock),
    .arst_n(arst_n),
    .sample_in(sample_b),
    .trim_value(trim_b),
    .sync_pulse(trim_sync),
    .sleep(sleep_b),
    .sample_out(corrected_b)
  );

  wire [READ_START_BITS-1:0] read_start =
      trim_b_word[READ_START_LSB +: READ_START_BITS];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fifo_read_ptr <= '0;
    end else if (sync_rise) begin
      fifo_read_ptr <= read_start;
    end else begin
      fifo_read_ptr <= fifo_read_ptr + 3'd1;
    end
  end

  // power controls and coarse gain come straight from register flops, gain steps are registered one cycle later
  // coarse gain field
  wire [GAIN_BITS-1:0] gain_code = power_word[GAIN_LSB +: GAIN_BITS];
  assign coarse_gain = gain_code;
  assign fuse_sleep = power_word[FUSE_SLEEP_BIT];
  assign tsense_sleep = power_word[TSENSE_SLEEP_BIT];
  assign clk_receiver_ena = power_word[CLKRECV_ENA_BIT];
  assign sleep_a = power_word[SLEEP_A_BIT];
  assign sleep_b = power_word[SLEEP_B_BIT];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gain_steps <= 5'h10;
    end else begin
      gain_steps <= {1'b0, gain_code} + 5'd1;
    end
  end

  // check words: five from registers, three from the neighbouring register bank
  logic [SAMPLE_BITS-1:0] check_word [CHECK_WORDS];
  for (genvar w = 0; w < CHECK_REG_WORDS; w++) begin : g_check
    assign check_word[w] = cfg_q[IDX_CHECK0 + w][SAMPLE_BITS-1:0];
  end
  assign check_word[5] = check_word5;
  assign check_word[6] = check_word6;
  assign check_word[7] = check_word7;

  chk_state_t chk_state_q;
  chk_state_t chk_state_d;
  logic [2:0] chk_index_q;

  // word zero is expected in the same cycle as the sync rising edge
  // alignment to sync edge
  wire chk_start = iotest_ena && sync_rise;
  wire [2:0] chk_sel = chk_start ? 3'd0 : chk_index_q;
  wire chk_active = chk_start || (chk_state_q == CHK_RUN && iotest_ena);
  wire chk_mismatch = chk_active && data_in != check_word[chk_sel];

  always_comb begin
    chk_state_d = chk_state_q;
    case (chk_state_q)
      CHK_IDLE: begin
        if (chk_start) begin
          chk_state_d = CHK_RUN;
        end
      end
      CHK_RUN: begin
        if (!iotest_ena) begin
          chk_state_d = CHK_IDLE;
        end
      end
      default: begin
        chk_state_d = CHK_IDLE;
      end
    endcase
  end

  // a new test clears the error, but a mismatch on its first word still sets it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chk_state_q <= CHK_IDLE;
      chk_index_q <= '0;
      pattern_error <= 1'b0;
    end else begin
      chk_state_q <= chk_state_d;
      chk_index_q <= chk_active ? chk_sel + 3'd1 : 3'd0;
      if (chk_mismatch) begin
        pattern_error <= 1'b1;
      end else if (chk_start) begin
        pattern_error <= 1'b0;
      end
    end
  end

  assign pattern_busy = chk_state_q == CHK_RUN;

endmodule // dac_trim_regs
`default_nettype wire

// ---- verilog/dc_trim_channel.sv ----
`timescale 1ns/100ps
`default_nettype none
module dc_trim_channel
  import dac_trim_pkg::*;
#(
  parameter int SAMPLE_W = SAMPLE_BITS,
  parameter int TRIM_W = TRIM_BITS
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [TRIM_W-1:0] trim_value,
  input wire logic sync_pulse,
  input wire logic sleep,
  output logic [SAMPLE_W-1:0] sample_out
);

  logic [TRIM_W-1:0] active_q;

  wire [SAMPLE_W:0] sample_ext = {sample_in[SAMPLE_W-1], sample_in};
  wire [SAMPLE_W:0] trim_ext = {{(SAMPLE_W + 1 - TRIM_W){active_q[TRIM_W-1]}}, active_q};
  wire [SAMPLE_W:0] sum = sample_ext + trim_ext;
  wire overflow = sum[SAMPLE_W] != sum[SAMPLE_W-1];
  // clip instead of wrapping, a wrapped code would be a full-scale glitch
  wire [SAMPLE_W-1:0] clipped = overflow ?
      {sum[SAMPLE_W], {(SAMPLE_W - 1){~sum[SAMPLE_W]}}} : sum[SAMPLE_W-1:0];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= '0;
      sample_out <= '0;
    end else begin
      if (sync_pulse) begin
        active_q <= trim_value;
      end
      sample_out <= sleep ? '0 : clipped;
    end
  end

endmodule // dc_trim_channel
`default_nettype wire

// ---- verilog/sif_serial_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module sif_serial_port
  import dac_trim_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sif_sel_n,
  input wire logic sif_clk,
  input wire logic sif_din,
  output logic sif_dout,
  output logic sif_dout_oe,
  output logic [6:0] reg_addr,
  output logic [15:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [15:0] rd_data
);

  logic sclk_last_q;
  logic [4:0] count_q;
  logic [22:0] shift_q;
  logic reading_q;
  logic [15:0] out_q;

  wire sclk_rise = sif_clk & ~sclk_last_q;
  wire sclk_fall = ~sif_clk & sclk_last_q;
  wire [23:0] frame_now = {shift_q, sif_din};
  wire in_frame = count_q < 5'(SIF_FRAME_BITS);
  wire bit_taken = sclk_rise && in_frame;
  wire header_done = bit_taken && count_q == 5'(SIF_HEADER_BITS - 1);
  wire frame_done = bit_taken && count_q == 5'(SIF_FRAME_BITS - 1);

  // serial clock is sampled by the core clock, so each phase must span three core cycles
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sclk_last_q <= 1'b0;
      count_q <= '0;
      shift_q <= '0;
      reading_q <= 1'b0;
      out_q <= '0;
      sif_dout <= 1'b0;
      sif_dout_oe <= 1'b0;
      reg_addr <= '0;
      wr_data <= '0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
    end else begin
      sclk_last_q <= sif_clk;
      wr_stb <= frame_done && !reading_q && !sif_sel_n;
      rd_stb <= header_done && frame_now[7] && !sif_sel_n;
      if (sif_sel_n) begin
        count_q <= '0;
        reading_q <= 1'b0;
        sif_dout_oe <= 1'b0;
      end else begin
        if (bit_taken) begin
          shift_q <= frame_now[22:0];
          count_q <= count_q + 5'd1;
        end
        if (header_done) begin
          reg_addr <= frame_now[6:0];
          reading_q <= frame_now[7];
        end
        if (frame_done && !reading_q) begin
          wr_data <= frame_now[15:0];
        end
        if (rd_stb) begin
          out_q <= rd_data;
          sif_dout_oe <= 1'b1;
        end else if (sclk_fall && sif_dout_oe) begin
          sif_dout <= out_q[15];
          out_q <= {out_q[14:0], 1'b0};
        end
      end
    end
  end

endmodule // sif_serial_port
`default_nettype wire
